/* prc_pin_route.v */
// Pin multiplexer and peripheral route configuration block with an APB register slave.
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "prc_regs.vh"

module prc_pin_route
(
    input  wire         clk,
    input  wire         rstn,
    // APB slave
    input  wire         psel,
    input  wire         penable,
    input  wire         pwrite,
    input  wire [11:0]  paddr,
    input  wire [31:0]  pwdata,
    output reg          pready,
    output reg  [31:0]  prdata,
    output reg          pslverr,
    // Port pin multiplexers
    input  wire [7:0]   port1Gpio,
    input  wire [7:0]   port1Periph,
    input  wire [7:0]   port2Gpio,
    input  wire [7:0]   port2Periph,
    input  wire [7:0]   port3Gpio,
    input  wire [7:0]   port3Periph,
    output reg  [7:0]   port1Pin,
    output reg  [7:0]   port2Pin,
    output reg  [7:0]   port3Pin,
    // Extra pin multiplexers: bit order refresh, tmr2, cs5, clear_to_send_ch1_n, serial_tx_ch1, terminal_ready_ch1_n, request_to_send_ch1_n
    input  wire [6:0]   extraAltOne,
    input  wire [6:0]   extraAltZero,
    output reg  [6:0]   extraPin,
    // Coprocessor and timer-2 trio, index 0 request/clock, 1 busy/gate, 2 error/out
    input  wire [2:0]   coprocPins,
    input  wire [2:0]   timer2Pins,
    output reg  [2:0]   coprocToCore,
    output reg  [2:0]   timer2FromPins,
    // Unmultiplexed pins
    input  wire         extDmaReqPin0,
    input  wire         extDmaReqPin1,
    input  wire         syncTransmitClockPin,
    input  wire         syncReceiveDataPin,
    output reg          carrierDetectCh1N,
    output reg          serialRxCh1,
    output reg          setReadyCh1N,
    output reg          ringIndicateCh1N,
    // DMA
    input  wire         dmaAckCh0N,
    input  wire         dmaAckCh1N,
    output reg          dmaAckCh0PinOe,
    output reg          dmaAckCh1PinOe,
    input  wire [4:0]   dmaSrcCh0,
    input  wire [4:0]   dmaSrcCh1,
    output reg          dmaChannel0Request,
    output reg          dmaChannel1Request,
    // Timers, index per counter
    input  wire         prescaledClock,
    input  wire [2:0]   timerClockPin,
    input  wire [2:0]   timerGatePin,
    output reg  [2:0]   timerClock,
    output reg  [2:0]   timerGate,
    // Interrupts
    input  wire [7:4]   extIrqPin,
    input  wire         syncPortIrq,
    input  wire [2:0]   cascadeAddressLines,
    output reg  [2:0]   cascadePins,
    output reg  [2:0]   cascadePinsOe,
    output reg  [6:0]   slaveIrq,
    // Serial clocks and modem routing
    input  wire         quarterRateSerialClock,
    input  wire         externalBaudClock,
    output reg          syncPortBaudClock,
    output reg          serialCh0BaudClock,
    output reg          serialCh1BaudClock,
    output reg          modemInternalCh0,
    output reg          modemInternalCh1
);

// ============================================================
// Registers
reg [7:0] port1Sel_q;
reg [7:0] port2Sel_q;
reg [7:0] port3Sel_q;
reg [7:0] extraSel_q;
reg [7:0] dmaRoute_q;
reg [7:0] timerRoute_q;
reg [7:0] intrRoute_q;
reg [7:0] serialRoute_q;

wire wrStrobe = psel && penable && pwrite;
wire rdSetup  = psel && !penable && !pwrite;

// Address decode used only for the pslverr response; returns 0 for unmapped.
function mapped;
    input [11:0] a;
    begin
        mapped = (a == `PRC_OFF_PORT1) || (a == `PRC_OFF_PORT2) || (a == `PRC_OFF_PORT3)
              || (a == `PRC_OFF_EXTRA) || (a == `PRC_OFF_DMA) || (a == `PRC_OFF_TIMER)
              || (a == `PRC_OFF_INTR) || (a == `PRC_OFF_SERIAL);
    end
endfunction

// Selects the DMA request from a five-entry source vector; codes above 4 give no request.
function dmaPick;
    input [2:0] code;
    input [4:0] src;
    begin
        if (code <= `PRC_SRC_TIMER2)
        begin
            dmaPick = src[code];
        end
        else
        begin
            dmaPick = 1'b0;
        end
    end
endfunction

// Zero wait states: pready is registered high during the access phase only.
always @(posedge clk or negedge rstn)
begin
    if (!rstn)
    begin
        port1Sel_q    <= `PRC_RST_VALUE;
        port2Sel_q    <= `PRC_RST_VALUE;
        port3Sel_q    <= `PRC_RST_VALUE;
        extraSel_q    <= `PRC_RST_VALUE;
        dmaRoute_q    <= `PRC_RST_VALUE;
        timerRoute_q  <= `PRC_RST_VALUE;
        intrRoute_q   <= `PRC_RST_VALUE;
        serialRoute_q <= `PRC_RST_VALUE;
        pready        <= 1'b0;
        pslverr       <= 1'b0;
        prdata        <= 32'h00000000;
    end
    else
    begin
        pready  <= psel && !penable;
        pslverr <= psel && !penable && !mapped(paddr);
        if (wrStrobe && pready)
        begin
            // Reserved bits are masked so they never store a value.
            if (paddr == `PRC_OFF_PORT1)
                port1Sel_q <= pwdata[7:0];
            else if (paddr == `PRC_OFF_PORT2)
                port2Sel_q <= pwdata[7:0];
            else if (paddr == `PRC_OFF_PORT3)
                port3Sel_q <= pwdata[7:0];
            else if (paddr == `PRC_OFF_EXTRA)
                extraSel_q <= pwdata[7:0] & `PRC_MASK_EXTRA;
            else if (paddr == `PRC_OFF_DMA)
                dmaRoute_q <= pwdata[7:0];
            else if (paddr == `PRC_OFF_TIMER)
                timerRoute_q <= pwdata[7:0] & `PRC_MASK_TIMER;
            else if (paddr == `PRC_OFF_INTR)
                intrRoute_q <= pwdata[7:0] & `PRC_MASK_INTR;
            else if (paddr == `PRC_OFF_SERIAL)
                serialRoute_q <= pwdata[7:0] & `PRC_MASK_SERIAL;
        end
        if (rdSetup)
        begin
            // Read data is captured in the setup cycle so it stands for the whole access phase.
            if (paddr == `PRC_OFF_PORT1)
                prdata <= {24'h000000, port1Sel_q};
            else if (paddr == `PRC_OFF_PORT2)
                prdata <= {24'h000000, port2Sel_q};
            else if (paddr == `PRC_OFF_PORT3)
                prdata <= {24'h000000, port3Sel_q};
            else if (paddr == `PRC_OFF_EXTRA)
                prdata <= {24'h000000, extraSel_q};
            else if (paddr == `PRC_OFF_DMA)
                prdata <= {24'h000000, dmaRoute_q};
            else if (paddr == `PRC_OFF_TIMER)
                prdata <= {24'h000000, timerRoute_q};
            else if (paddr == `PRC_OFF_INTR)
                prdata <= {24'h000000, intrRoute_q};
            else if (paddr == `PRC_OFF_SERIAL)
                prdata <= {24'h000000, serialRoute_q};
            else
                prdata <= 32'h00000000;
        end
    end
end

// ============================================================
// Routing
// Every output is registered, so routed signals lag by one clock; clocks routed here
// must therefore be well below half the system clock.
genvar i;
generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_port
        always @(posedge clk or negedge rstn)
        begin
            if (!rstn)
            begin
                port1Pin[i] <= 1'b0;
                port2Pin[i] <= 1'b0;
                port3Pin[i] <= 1'b0;
            end
            else
            begin
                port1Pin[i] <= port1Sel_q[i] ? port1Periph[i] : port1Gpio[i];
                port2Pin[i] <= port2Sel_q[i] ? port2Periph[i] : port2Gpio[i];
                port3Pin[i] <= port3Sel_q[i] ? port3Periph[i] : port3Gpio[i];
            end
        end
    end
    for (i = 0; i < 3; i = i + 1)
    begin : g_timer
        always @(posedge clk or negedge rstn)
        begin
            if (!rstn)
            begin
                timerClock[i] <= 1'b0;
                timerGate[i]  <= 1'b1;
            end
            else
            begin
                timerGate[i]  <= timerRoute_q[2 * i + 1] ? timerGatePin[i] : 1'b1;
                timerClock[i] <= !timerRoute_q[`PRC_TMR_CLK_STOP]
                                 && (timerRoute_q[2 * i] ? timerClockPin[i] : prescaledClock);
            end
        end
    end
endgenerate

// ============================================================
// Extra pin multiplexers
always @(posedge clk or negedge rstn)
begin
    if (!rstn)
    begin
        extraPin <= 7'h00;
    end
    else
    begin
        extraPin <= (extraSel_q[6:0] & extraAltOne) | (~extraSel_q[6:0] & extraAltZero);
    end
end

// ============================================================
// Coprocessor and timer-2 trio
always @(posedge clk or negedge rstn)
begin
    if (!rstn)
    begin
        coprocToCore   <= 3'h0;
        timer2FromPins <= 3'h0;
    end
    else
    begin
        // The unselected group sees idle zeros, so it cannot act on the other group's edges.
        coprocToCore   <= extraSel_q[`PRC_EXT_TMR2] ? 3'h0 : coprocPins;
        timer2FromPins <= extraSel_q[`PRC_EXT_TMR2] ? timer2Pins : 3'h0;
    end
end

// ============================================================
// Unmultiplexed pins
always @(posedge clk or negedge rstn)
begin
    if (!rstn)
    begin
        carrierDetectCh1N <= 1'b1;
        serialRxCh1       <= 1'b1;
        setReadyCh1N      <= 1'b1;
        ringIndicateCh1N  <= 1'b1;
    end
    else
    begin
        // Pins without a multiplexer drive both of their inputs.
        carrierDetectCh1N <= extDmaReqPin0;
        serialRxCh1       <= extDmaReqPin1;
        setReadyCh1N      <= syncTransmitClockPin;
        ringIndicateCh1N  <= syncReceiveDataPin;
    end
end

// ============================================================
// DMA routing
always @(posedge clk or negedge rstn)
begin
    if (!rstn)
    begin
        dmaAckCh0PinOe     <= 1'b0;
        dmaAckCh1PinOe     <= 1'b0;
        dmaChannel0Request <= 1'b0;
        dmaChannel1Request <= 1'b0;
    end
    else
    begin
        // Output enable also needs the pin mux to give the pin to the acknowledge.
        dmaAckCh0PinOe <= !dmaRoute_q[`PRC_DMA_ACK0_OFF] && !extraSel_q[`PRC_EXT_CS5];
        dmaAckCh1PinOe <= !dmaRoute_q[`PRC_DMA_ACK1_OFF] && !extraSel_q[`PRC_EXT_SERIAL_TX_CH1];
        // Codes 5 to 7 have no source, so the request stays low rather than picking a stray input.
        dmaChannel0Request <= dmaPick(dmaRoute_q[`PRC_DMA_SRC0_HI:`PRC_DMA_SRC0_LO], dmaSrcCh0);
        dmaChannel1Request <= dmaPick(dmaRoute_q[`PRC_DMA_SRC1_HI:`PRC_DMA_SRC1_LO], dmaSrcCh1);
    end
end

// ============================================================
// Cascade lines
always @(posedge clk or negedge rstn)
begin
    if (!rstn)
    begin
        cascadePins   <= 3'h0;
        cascadePinsOe <= 3'h0;
    end
    else
    begin
        cascadePins   <= cascadeAddressLines;
        cascadePinsOe <= {3{intrRoute_q[`PRC_INT_CAS_EN]}};
    end
end

// ============================================================
// Slave interrupt inputs
always @(posedge clk or negedge rstn)
begin
    if (!rstn)
    begin
        slaveIrq <= 7'h00;
    end
    else
    begin
        // Slave inputs 2 to 4 are not routed by this block and stay low.
        slaveIrq[6]   <= intrRoute_q[`PRC_INT_IR6] & extIrqPin[7];
        slaveIrq[5]   <= intrRoute_q[`PRC_INT_IR5] & extIrqPin[6];
        slaveIrq[4:2] <= 3'h0;
        slaveIrq[1]   <= intrRoute_q[`PRC_INT_IR1] ? extIrqPin[5] : syncPortIrq;
        slaveIrq[0]   <= intrRoute_q[`PRC_INT_IR0] & extIrqPin[4];
    end
end

// ============================================================
// Serial clocks and modem routing
always @(posedge clk or negedge rstn)
begin
    if (!rstn)
    begin
        syncPortBaudClock  <= 1'b0;
        serialCh0BaudClock <= 1'b0;
        serialCh1BaudClock <= 1'b0;
        modemInternalCh0   <= 1'b0;
        modemInternalCh1   <= 1'b0;
    end
    else
    begin
        modemInternalCh1 <= serialRoute_q[`PRC_SIO_MODEM1];
        modemInternalCh0 <= serialRoute_q[`PRC_SIO_MODEM0];
        syncPortBaudClock  <= serialRoute_q[`PRC_SIO_SYNC_SERIAL_PORT_CLK] ? quarterRateSerialClock : prescaledClock;
        serialCh1BaudClock <= serialRoute_q[`PRC_SIO_CH1_CLK] ? quarterRateSerialClock : externalBaudClock;
        serialCh0BaudClock <= serialRoute_q[`PRC_SIO_CH0_CLK] ? quarterRateSerialClock : externalBaudClock;
    end
end

endmodule

`default_nettype wire

/* prc_pin_route_properties.sv */
// Concurrent checks on the ports of the pin and route block.
`timescale 1ns/10ps
`default_nettype none
`include "prc_regs.vh"
module prc_pin_route_properties
(
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    input wire logic [6:0]  slaveIrq,
    input wire logic [7:4]  extIrqPin,
    input wire logic [2:0]  timerGate,
    input wire logic [2:0]  timerGatePin,
    input wire logic [2:0]  timerClock,
    input wire logic [2:0]  timerClockPin,
    input wire logic        prescaledClock,
    input wire logic        carrierDetectCh1N,
    input wire logic        extDmaReqPin0,
    input wire logic [2:0]  cascadePinsOe,
    input wire logic        serialCh0BaudClock,
    input wire logic        quarterRateSerialClock,
    input wire logic        externalBaudClock
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // ============================================================
    // Bus handshake
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        pready ##1 !pready;
    endsequence
    a_ready_after_setup: assert property (s_setup |=> s_access) else $error("pready late");
    a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
    a_upper_read_zero: assert property (prdata[31:8] == 24'h0) else $error("prdata upper bits set");
    // ============================================================
    // Routes; a route may only pass what its sources offered one edge before.
    a_slave_ir_six: assert property (slaveIrq[6] |-> $past(extIrqPin[7])) else $error("slave input 6 bad");
    a_gate_zero_src: assert property (!timerGate[0] |-> !$past(timerGatePin[0])) else $error("gate 0 bad");
    a_clock_zero_src: assert property (timerClock[0] |-> $past(prescaledClock) || $past(timerClockPin[0]))
        else $error("timer clock 0 bad");
    a_unmuxed_pair: assert property ($past(rstn) |-> carrierDetectCh1N == $past(extDmaReqPin0))
        else $error("carrier copy bad");
    a_cascade_oe_all: assert property (cascadePinsOe == 3'h0 || cascadePinsOe == 3'h7)
        else $error("cascade enables split");
    a_baud_zero_src: assert property (serialCh0BaudClock |->
        $past(quarterRateSerialClock) || $past(externalBaudClock)) else $error("baud clock 0 bad");
    // A write to the interrupt routing register reaches the cascade enables two edges later.
    sequence s_intr_write;
        psel && penable && pwrite && pready && paddr == `PRC_OFF_INTR;
    endsequence
    a_cascade_from_write: assert property (s_intr_write |-> ##2 cascadePinsOe == {3{$past(pwdata[7], 2)}})
        else $error("cascade enable not from write");
endmodule
bind prc_pin_route prc_pin_route_properties u_props (.*);
`default_nettype wire

/* prc_regs.vh */
// Register offsets, field positions, reset values and writable masks of the pin and route block.
`ifndef PRC_REGS_VH
`define PRC_REGS_VH
// ============================================================
// Register byte offsets
`define PRC_OFF_PORT1      12'h000
`define PRC_OFF_PORT2      12'h004
`define PRC_OFF_PORT3      12'h008
`define PRC_OFF_EXTRA      12'h00C
`define PRC_OFF_DMA        12'h010
`define PRC_OFF_TIMER      12'h014
`define PRC_OFF_INTR       12'h018
`define PRC_OFF_SERIAL     12'h01C
// ============================================================
// Reset values
`define PRC_RST_VALUE      8'h00
// ============================================================
// Writable bit masks
`define PRC_MASK_FULL      8'hFF
`define PRC_MASK_EXTRA     8'h7F
`define PRC_MASK_TIMER     8'hBF
`define PRC_MASK_INTR      8'h8F
`define PRC_MASK_SERIAL    8'hC7
// ============================================================
// Field positions
`define PRC_EXT_REFRESH    6
`define PRC_EXT_TMR2       5
`define PRC_EXT_CS5        4
`define PRC_EXT_CLEAR_TO_SEND_CH1_N       3
`define PRC_EXT_SERIAL_TX_CH1       2
`define PRC_EXT_TERMINAL_READY_CH1_N       1
`define PRC_EXT_REQUEST_TO_SEND_CH1_N       0
`define PRC_DMA_ACK1_OFF   7
`define PRC_DMA_SRC1_HI    6
`define PRC_DMA_SRC1_LO    4
`define PRC_DMA_ACK0_OFF   3
`define PRC_DMA_SRC0_HI    2
`define PRC_DMA_SRC0_LO    0
`define PRC_TMR_CLK_STOP   7
`define PRC_INT_CAS_EN     7
`define PRC_INT_IR6        3
`define PRC_INT_IR5        2
`define PRC_INT_IR1        1
`define PRC_INT_IR0        0
`define PRC_SIO_MODEM1     7
`define PRC_SIO_MODEM0     6
`define PRC_SIO_SYNC_SERIAL_PORT_CLK   2
`define PRC_SIO_CH1_CLK    1
`define PRC_SIO_CH0_CLK    0
// ============================================================
// DMA request source codes
`define PRC_SRC_PIN        3'h0
`define PRC_SRC_SIO_A      3'h1
`define PRC_SRC_SIO_B      3'h2
`define PRC_SRC_SYNC_SERIAL_PORT       3'h3
`define PRC_SRC_TIMER2     3'h4
`endif

/* prc_tb.sv */
// Self-checking bench for the pin and route block.
`timescale 1ns/10ps
`default_nettype none
`include "prc_regs.vh"
module tb;
    logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, errv;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdv;
    logic [7:0] port1Gpio = 8'hA5, port1Periph = 8'h5A, port2Gpio = 8'h3C, port2Periph = 8'hC3;
    logic [7:0] port3Gpio = 8'h0F, port3Periph = 8'hF0, port1Pin, port2Pin, port3Pin;
    logic [6:0] extraAltOne = 7'h2B, extraAltZero = 7'h54, extraPin, slaveIrq;
    logic [2:0] coprocPins = 3'h5, timer2Pins = 3'h3, coprocToCore, timer2FromPins;
    logic extDmaReqPin0 = 0, extDmaReqPin1 = 1, syncTransmitClockPin = 0, syncReceiveDataPin = 1;
    logic carrierDetectCh1N, serialRxCh1, setReadyCh1N, ringIndicateCh1N;
    logic dmaAckCh0N = 1, dmaAckCh1N = 0, dmaAckCh0PinOe, dmaAckCh1PinOe;
    logic [4:0] dmaSrcCh0 = 5'h15, dmaSrcCh1 = 5'h0A;
    logic dmaChannel0Request, dmaChannel1Request, syncPortBaudClock, serialCh0BaudClock;
    logic prescaledClock = 1, quarterRateSerialClock = 0, externalBaudClock = 1, syncPortIrq = 1;
    logic [2:0] timerClockPin = 3'h5, timerGatePin = 3'h2, timerClock, timerGate, cascadePins, cascadePinsOe;
    logic [7:4] extIrqPin = 4'hA;
    logic [2:0] cascadeAddressLines = 3'h6;
    logic serialCh1BaudClock, modemInternalCh0, modemInternalCh1;
    logic [7:0] r[8];
    logic [7:0] m[8] = '{8'hFF, 8'hFF, 8'hFF, `PRC_MASK_EXTRA, 8'hFF, `PRC_MASK_TIMER, `PRC_MASK_INTR, `PRC_MASK_SERIAL};
    int fails = 0, check_count = 0;
    prc_pin_route u_dut (.*);
    always #20 clk = ~clk;
    // ============================================================
    // Bus and compare helpers
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel <= 0; penable <= 0;
        @(posedge clk);
    endtask
    function automatic logic req(input logic [2:0] c, input logic [4:0] s);
        return (c < 5) ? s[c] : 1'b0;
    endfunction
    task automatic routes();
        logic [2:0] ec, eg;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 3; i++)
        begin
            ec[i] = !r[5][7] && (r[5][2*i] ? timerClockPin[i] : prescaledClock);
            eg[i] = r[5][2*i+1] ? timerGatePin[i] : 1'b1;
        end
        chk("p1", (port1Periph & r[0]) | (port1Gpio & ~r[0]), port1Pin);
        chk("p2", (port2Periph & r[1]) | (port2Gpio & ~r[1]), port2Pin);
        chk("p3", (port3Periph & r[2]) | (port3Gpio & ~r[2]), port3Pin);
        chk("ex", (extraAltOne & r[3][6:0]) | (extraAltZero & ~r[3][6:0]), extraPin);
        chk("trio", r[3][5] ? {3'h0, timer2Pins} : {coprocPins, 3'h0}, {coprocToCore, timer2FromPins});
        chk("pairs", {extDmaReqPin0, extDmaReqPin1, syncTransmitClockPin, syncReceiveDataPin},
            {carrierDetectCh1N, serialRxCh1, setReadyCh1N, ringIndicateCh1N});
        chk("ackoe", {!r[4][7] && !r[3][2], !r[4][3] && !r[3][4]}, {dmaAckCh1PinOe, dmaAckCh0PinOe});
        chk("dreq", {req(r[4][6:4], dmaSrcCh1), req(r[4][2:0], dmaSrcCh0)},
            {dmaChannel1Request, dmaChannel0Request});
        chk("tmr", {ec, eg}, {timerClock, timerGate});
        chk("cas", {{3{r[6][7]}}, cascadeAddressLines}, {cascadePinsOe, cascadePins});
        chk("slv", {r[6][3] & extIrqPin[7], r[6][2] & extIrqPin[6], 3'h0,
            r[6][1] ? extIrqPin[5] : syncPortIrq, r[6][0] & extIrqPin[4]}, slaveIrq);
        chk("sio", {r[7][7:6], r[7][2] ? quarterRateSerialClock : prescaledClock,
            r[7][1] ? quarterRateSerialClock : externalBaudClock, r[7][0] ? quarterRateSerialClock : externalBaudClock},
            {modemInternalCh1, modemInternalCh0, syncPortBaudClock, serialCh1BaudClock, serialCh0BaudClock});
    endtask
    task automatic flip();
        {port1Gpio, port1Periph, port2Gpio, port2Periph, port3Gpio, port3Periph, extraAltOne, extraAltZero} <=
            ~{port1Gpio, port1Periph, port2Gpio, port2Periph, port3Gpio, port3Periph, extraAltOne, extraAltZero};
        {coprocPins, timer2Pins, extDmaReqPin0, extDmaReqPin1, syncTransmitClockPin, syncReceiveDataPin} <=
            ~{coprocPins, timer2Pins, extDmaReqPin0, extDmaReqPin1, syncTransmitClockPin, syncReceiveDataPin};
        {dmaAckCh0N, dmaAckCh1N, dmaSrcCh0, dmaSrcCh1, prescaledClock, timerClockPin, timerGatePin} <=
            ~{dmaAckCh0N, dmaAckCh1N, dmaSrcCh0, dmaSrcCh1, prescaledClock, timerClockPin, timerGatePin};
        {extIrqPin, syncPortIrq, cascadeAddressLines, quarterRateSerialClock, externalBaudClock} <=
            ~{extIrqPin, syncPortIrq, cascadeAddressLines, quarterRateSerialClock, externalBaudClock};
        @(posedge clk);
    endtask
    // ============================================================
    // Scenarios
    task automatic t_reset();
        for (int i = 0; i < 8; i++)
        begin
            r[i] = 8'h00;
            apb(12'(4 * i), 0, 8'h00);
            chk("rst", 32'h0, rdv);
        end
        routes();
    endtask
    task automatic t_regs();
        for (int i = 0; i < 8; i++)
        begin
            apb(12'(4 * i), 1, 8'hFF);
            apb(12'(4 * i), 0, 8'h00);
            chk("mask", {24'h0, m[i]}, rdv);
            chk("slverr", 32'h0, errv);
        end
        apb(12'h020, 1, 8'hFF);
        chk("unmapped err", 32'h1, errv);
        apb(12'h020, 0, 8'h00);
        chk("unmapped read", 32'h1, {rdv[31:1], errv});
    endtask
    task automatic t_patterns();
        logic [7:0] pat[4] = '{8'h55, 8'hAA, 8'hFF, 8'h00};
        for (int p = 0; p < 4; p++)
        begin
            for (int i = 0; i < 8; i++)
            begin
                r[i] = pat[p] & m[i];
                apb(12'(4 * i), 1, pat[p]);
            end
            routes();
            flip();
            routes();
        end
    endtask
    task automatic t_dma_codes();
        for (int k = 0; k < 8; k++)
        begin
            r[4] = {k[0], k[2:0], ~k[0], 3'(7 - k)};
            apb(`PRC_OFF_DMA, 1, r[4]);
            routes();
        end
    endtask
    task automatic t_mid_reset();
        for (int i = 0; i < 8; i++)
        begin
            apb(12'(4 * i), 1, 8'hFF);
        end
        rstn <= 0;
        repeat (2) @(posedge clk);
        rstn <= 1;
        @(posedge clk);
        t_reset();
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        #400000;
        fails++;
        close_out();
    end
    initial
    begin
        repeat (16) @(posedge clk);
        rstn <= 1;
        @(posedge clk);
        t_reset();
        t_regs();
        t_patterns();
        t_dma_codes();
        t_mid_reset();
        close_out();
    end
endmodule
`default_nettype wire
